// ---- rtl/wdt_pkg.sv ----
// Constants, types and helpers shared by the watchdog device end and its bus controller.
// Assumes a single 40 MHz clock on both ends and byte-indexed registers on the link.
// Contract
// (R01) Watchdog overflow sets flag, never interval mode
// (R02) Flag clears by zero write after read
// (R03) Reset enable makes overflow reset chip
// (R04) Disabled reset still clears counter, control
// (R05) Kind select: 0 power-on, 1 manual
// (R06) Reserved status bits read one, write one
// (R07) Mode one and run one: watchdog
// (R08) Software reloads counter before it overflows
// (R09) Overflow output lasts 128 clock cycles
// (R10) Internal reset starts together, lasts 512
// (R11) Pin reset wins and clears flag
// (R12) Watchdog reset spares port registers
// (R13) Mode zero, run one: interval timer
// (R14) No standby while timer runs
// (R15) Software picks divider covering settle time
// (R16) Wake counts, wrap to zero leaves standby
// (R17) Interval overflow sets flag, interrupt together
// (R18) Interrupt follows flag; handler clears it
// (R19) Run off holds counter at zero
// (R20) Divider codes select /2 up to /8192
// (R21) Counter, control via keyed word writes
// (R22) Status register keyed word writes
// (R23) Eight-bit counter, overflow is wrap
package wdt_pkg;

	localparam int CNT_W = 8;
	localparam int PRE_W = 13;

	// Register indices on the link (read: 0 control, 1 counter, 3 status)
	localparam logic [1:0] IDX_CTRL  = 2'h0;
	localparam logic [1:0] IDX_CNT   = 2'h1;
	localparam logic [1:0] IDX_RSTW  = 2'h2;
	localparam logic [1:0] IDX_RSTRD = 2'h3;

	// Upper-byte keys of word writes
	localparam logic [7:0] KEY_5A = 8'h5A;
	localparam logic [7:0] KEY_A5 = 8'hA5;
	localparam logic [7:0] ZERO_B = 8'h00;

	// Field positions
	localparam int B_FLAG = 7;
	localparam int B_MODE = 6;
	localparam int B_RUN  = 5;
	localparam int B_CHIP_RESET_ENABLE = 6;
	localparam int B_RESET_KIND_SELECT = 5;

	// Reserved ones and reset values
	localparam logic [7:0] CTRL_RSV = 8'h18;
	localparam logic [7:0] STAT_RSV = 8'h1F;
	localparam logic [7:0] CNT_INIT = 8'h00;
	localparam logic [7:0] CNT_TOP  = 8'hFF;

	// Pulse lengths in clock cycles
	localparam int OVF_OUT_CYC = 128;
	localparam int INT_RST_CYC = 512;

	// Controller register offsets and command fields
	localparam logic [7:0] H_CMD  = 8'h00;
	localparam logic [7:0] H_STAT = 8'h04;
	localparam logic [7:0] H_STBY = 8'h08;
	localparam int CMD_WR   = 16;
	localparam int CMD_WORD = 17;
	localparam int CMD_IDX  = 18;

	typedef enum logic [1:0] {
		WDT_ACTIVE  = 2'b00,
		WDT_STANDBY = 2'b01,
		WDT_WAKING  = 2'b11
	} wdt_pwr_e;

	// Divider mask: tick when low bits all ones
	function automatic logic [PRE_W-1:0] wdt_div_mask(input logic [2:0] sel);
		case (sel)
			3'h0: wdt_div_mask = 13'h0001;
			3'h1: wdt_div_mask = 13'h003F;
			3'h2: wdt_div_mask = 13'h007F;
			3'h3: wdt_div_mask = 13'h00FF;
			3'h4: wdt_div_mask = 13'h01FF;
			3'h5: wdt_div_mask = 13'h03FF;
			3'h6: wdt_div_mask = 13'h0FFF;
			default: wdt_div_mask = 13'h1FFF;
		endcase
	endfunction

endpackage

// ---- rtl/wdt_if.sv ----
// Link between the watchdog device end and its controller end.
// Assumes both ends run on the same clock; requests are one-cycle pulses.
`timescale 1ns/1ps
interface wdt_if;
	logic        req;           // Access request pulse
	logic        wr;            // 1 write, 0 read
	logic        word;          // 1 word access, 0 byte
	logic [1:0]  idx;           // Register index
	logic [15:0] wdata;         // Write data, key in upper byte
	logic [7:0]  rdata;         // Read data
	logic        ack;           // Answer pulse
	logic        standby_req;   // Standby wish from software
	logic        standby_grant; // Standby in force

	modport dev (input req, wr, word, idx, wdata, standby_req,
		output rdata, ack, standby_grant);
	modport host (output req, wr, word, idx, wdata, standby_req,
		input rdata, ack, standby_grant);
endinterface

// ---- rtl/wdt_prescaler.sv ----
// Divides the system clock into counter ticks at the selected ratio.
// Assumes clear is a level from the same clock domain.
`timescale 1ns/1ps
module wdt_prescaler
	import wdt_pkg::*;
#(
	parameter int W = PRE_W
) (
	input  wire logic       hclk,    // System clock
	input  wire logic       hresetn, // Async reset, low
	input  wire logic       clear,   // Hold divider at zero
	input  wire logic [2:0] sel,     // Divider code
	output logic            tick_q   // One-cycle tick
);

	logic [W-1:0] div_q;

	//////////////////////////////////////////////////////////////////////////
	// Free divider, held while the counter is stopped
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_q <= '0;
		end else if (clear) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	// Tick when the selected low bits are all ones
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= !clear && ((div_q & W'(wdt_div_mask(sel))) == W'(wdt_div_mask(sel))); // R20
		end
	end

endmodule

// ---- rtl/wdt_device.sv ----
// Watchdog and interval timer, the device end of the link.
// Assumes pins arrive asynchronously; link signals share hclk.
`timescale 1ns/1ps
module wdt_device
	import wdt_pkg::*;
(
	input  wire logic hclk,             // System clock
	input  wire logic hresetn,          // Async reset, low
	wdt_if.dev        bus,              // Register link
	input  wire logic ext_reset_pin_n,  // External reset pin, low
	input  wire logic wake_pin,         // Interrupt wake request
	output logic      ext_ovf_out_n_q,  // Overflow output, low
	output logic      chip_reset_q,     // Internal chip reset
	output logic      reset_kind_q,     // 0 power-on, 1 manual
	output logic      interval_irq_q,   // Interval interrupt
	output logic      clock_stop_q,     // Clocks held off
	output logic      port_init_q       // Port registers init
);

	logic [1:0]     rst_sync_q;
	logic [1:0]     wake_sync_q;
	logic           pin_rst;
	logic           wake;
	logic           ovf_q, mode_q, run_q;
	logic [2:0]     cks_q;
	logic [CNT_W-1:0] cnt_q;
	logic           watchdog_overflow_flag_q, chip_reset_enable_q, reset_kind_select_q;
	logic           ovf_seen_q, watchdog_overflow_flag_seen_q;
	logic [6:0]     out_cnt_q;
	logic [8:0]     rst_cnt_q;
	wdt_pwr_e       pwr_q;
	logic           tick, counting;
	logic           wr_ok, cnt_wr, ctl_wr, st_clr, st_set;
	logic           ovf_evt, wd_ovf, it_ovf;
	logic [7:0]     ctrl_rd, stat_rd;

	//////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rst_sync_q  <= 2'h0;
			wake_sync_q <= 2'h0;
		end else begin
			rst_sync_q  <= {rst_sync_q[0], ext_reset_pin_n};
			wake_sync_q <= {wake_sync_q[0], wake_pin};
		end
	end

	assign pin_rst = !rst_sync_q[1];
	assign wake    = wake_sync_q[1];

	//////////////////////////////////////////////////////////////////////////
	// Keyed word write decode
	assign wr_ok  = bus.req && bus.wr && bus.word;
	assign cnt_wr = wr_ok && bus.idx == IDX_CTRL && bus.wdata[15:8] == KEY_5A; // R21
	assign ctl_wr = wr_ok && bus.idx == IDX_CTRL && bus.wdata[15:8] == KEY_A5; // R21
	assign st_clr = wr_ok && bus.idx == IDX_RSTW && bus.wdata == {KEY_A5, ZERO_B}; // R22
	assign st_set = wr_ok && bus.idx == IDX_RSTW && bus.wdata[15:8] == KEY_5A; // R22

	// Overflow events
	assign counting = run_q || pwr_q == WDT_WAKING;
	assign ovf_evt  = tick && cnt_q == CNT_TOP && !cnt_wr; // R23
	assign wd_ovf   = ovf_evt && run_q && mode_q; // R07
	assign it_ovf   = ovf_evt && run_q && !mode_q; // R13

	// Read views with reserved ones
	assign ctrl_rd = {ovf_q, mode_q, run_q, 2'b00, cks_q} | CTRL_RSV;
	assign stat_rd = {watchdog_overflow_flag_q, chip_reset_enable_q, reset_kind_select_q, 5'h00} | STAT_RSV; // R06

	wdt_prescaler #(
		.W(PRE_W)
	) u_pre (
		.hclk    (hclk),
		.hresetn (hresetn),
		.clear   (!counting),
		.sel     (cks_q),
		.tick_q  (tick)
	);

	//////////////////////////////////////////////////////////////////////////
	// Counter: write beats increment, overflow reloads zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= CNT_INIT;
		end else if (pin_rst || wd_ovf) begin
			cnt_q <= CNT_INIT; // R04
		end else if (cnt_wr) begin
			cnt_q <= bus.wdata[7:0];
		end else if (!counting) begin
			cnt_q <= CNT_INIT; // R19
		end else if (tick) begin
			cnt_q <= cnt_q + 1'b1; // R23
		end
	end

	// Control fields
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_q <= 1'b0;
			run_q  <= 1'b0;
			cks_q  <= 3'h0;
		end else if (pin_rst || wd_ovf) begin
			mode_q <= 1'b0; // R04
			run_q  <= 1'b0;
			cks_q  <= 3'h0;
		end else if (ctl_wr) begin
			mode_q <= bus.wdata[B_MODE];
			run_q  <= bus.wdata[B_RUN];
			cks_q  <= bus.wdata[2:0];
		end
	end

	// Interval flag; set wins over clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ovf_q <= 1'b0;
		end else if (pin_rst) begin
			ovf_q <= 1'b0;
		end else if (it_ovf) begin
			ovf_q <= 1'b1; // R17
		end else if (ctl_wr && ((!bus.wdata[B_FLAG] && ovf_seen_q)
				|| (!bus.wdata[B_RUN] && !mode_q))) begin
			ovf_q <= 1'b0; // R18
		end
	end

	// Interrupt mirrors the interval flag
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			interval_irq_q <= 1'b0;
		end else begin
			interval_irq_q <= (ovf_q || it_ovf) && !pin_rst; // R18
		end
	end

	// Read-as-set trackers for both flags
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ovf_seen_q  <= 1'b0;
			watchdog_overflow_flag_seen_q <= 1'b0;
		end else if (pin_rst) begin
			ovf_seen_q  <= 1'b0;
			watchdog_overflow_flag_seen_q <= 1'b0;
		end else begin
			if (bus.req && !bus.wr && bus.idx == IDX_CTRL && ovf_q) begin
				ovf_seen_q <= 1'b1;
			end else if (ctl_wr || !ovf_q) begin
				ovf_seen_q <= 1'b0;
			end
			if (bus.req && !bus.wr && bus.idx == IDX_RSTRD && watchdog_overflow_flag_q) begin
				watchdog_overflow_flag_seen_q <= 1'b1; // R02
			end else if (st_clr || !watchdog_overflow_flag_q) begin
				watchdog_overflow_flag_seen_q <= 1'b0;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Status register: flag, reset enable, reset kind
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			watchdog_overflow_flag_q <= 1'b0;
		end else if (pin_rst) begin
			watchdog_overflow_flag_q <= 1'b0; // R11
		end else if (wd_ovf) begin
			watchdog_overflow_flag_q <= 1'b1; // R01
		end else if (st_clr && watchdog_overflow_flag_seen_q) begin
			watchdog_overflow_flag_q <= 1'b0; // R02
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chip_reset_enable_q <= 1'b0;
			reset_kind_select_q <= 1'b0;
		end else if (pin_rst) begin
			chip_reset_enable_q <= 1'b0;
			reset_kind_select_q <= 1'b0;
		end else if (st_set) begin
			chip_reset_enable_q <= bus.wdata[B_CHIP_RESET_ENABLE]; // R22
			reset_kind_select_q <= bus.wdata[B_RESET_KIND_SELECT];
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Overflow output pulse
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_cnt_q       <= 7'h00;
			ext_ovf_out_n_q <= 1'b1;
		end else if (pin_rst) begin
			out_cnt_q       <= 7'h00;
			ext_ovf_out_n_q <= 1'b1;
		end else if (wd_ovf) begin
			out_cnt_q       <= 7'(OVF_OUT_CYC - 1); // R09
			ext_ovf_out_n_q <= 1'b0;
		end else if (out_cnt_q != 7'h00) begin
			out_cnt_q <= out_cnt_q - 1'b1;
		end else begin
			ext_ovf_out_n_q <= 1'b1;
		end
	end

	// Internal chip reset pulse and its kind
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rst_cnt_q    <= 9'h000;
			chip_reset_q <= 1'b0;
			reset_kind_q <= 1'b0;
		end else if (pin_rst) begin
			rst_cnt_q    <= 9'h000; // R11
			chip_reset_q <= 1'b0;
		end else if (wd_ovf && chip_reset_enable_q) begin
			rst_cnt_q    <= 9'(INT_RST_CYC - 1); // R10
			chip_reset_q <= 1'b1; // R03
			reset_kind_q <= reset_kind_select_q; // R05
		end else if (rst_cnt_q != 9'h000) begin
			rst_cnt_q <= rst_cnt_q - 1'b1;
		end else begin
			chip_reset_q <= 1'b0;
		end
	end

	// Port registers initialise on the pin only
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_init_q <= 1'b1;
		end else begin
			port_init_q <= pin_rst; // R12
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Standby entry and timed wake
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pwr_q <= WDT_ACTIVE;
		end else if (pin_rst) begin
			pwr_q <= WDT_ACTIVE;
		end else begin
			case (pwr_q)
				WDT_ACTIVE: begin
					if (bus.standby_req && !run_q) begin
						pwr_q <= WDT_STANDBY; // R14
					end
				end
				WDT_STANDBY: begin
					if (wake) begin
						pwr_q <= WDT_WAKING;
					end
				end
				WDT_WAKING: begin
					if (tick && cnt_q == CNT_TOP) begin
						pwr_q <= WDT_ACTIVE; // R16
					end
				end
				default: pwr_q <= WDT_ACTIVE;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clock_stop_q      <= 1'b0;
			bus.standby_grant <= 1'b0;
		end else begin
			clock_stop_q      <= pwr_q != WDT_ACTIVE;
			bus.standby_grant <= pwr_q != WDT_ACTIVE;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Read answer one cycle after the request
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus.ack   <= 1'b0;
			bus.rdata <= 8'h00;
		end else begin
			bus.ack <= bus.req;
			if (bus.req && !bus.wr) begin
				case (bus.idx)
					IDX_CTRL:  bus.rdata <= ctrl_rd;
					IDX_CNT:   bus.rdata <= cnt_q;
					IDX_RSTRD: bus.rdata <= stat_rd; // R06
					default:   bus.rdata <= 8'h00;
				endcase
			end
		end
	end

endmodule

// ---- rtl/wdt_host.sv ----
// Controller end: turns AHB-Lite register writes into link accesses.
// Assumes one AHB-Lite master, single word transfers, hready = hreadyout.
`timescale 1ns/1ps
module wdt_host
	import wdt_pkg::*;
(
	input  wire logic        hclk,      // System clock
	input  wire logic        hresetn,   // Async reset, low
	input  wire logic        hsel,      // Slave select
	input  wire logic [7:0]  haddr,     // Byte address
	input  wire logic [1:0]  htrans,    // Transfer type
	input  wire logic        hwrite,    // Write when high
	input  wire logic [2:0]  hsize,     // Transfer size
	input  wire logic        hready,    // Bus ready
	input  wire logic [31:0] hwdata,    // Write data
	output logic      [31:0] hrdata_q,  // Read data
	output logic             hreadyout_q, // Slave ready
	output logic             hresp_q,   // Always OKAY
	wdt_if.host              bus        // Register link
);

	logic       ap_wr_q;
	logic [7:0] ap_addr_q;
	logic       busy_q;
	logic [7:0] last_q;
	logic       ap_take;
	logic       launch;

	assign ap_take = hsel && htrans[1] && hready;
	assign launch  = ap_wr_q && ap_addr_q == H_CMD && !busy_q;

	//////////////////////////////////////////////////////////////////////////
	// Address phase capture, zero-wait answer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr_q     <= 1'b0;
			ap_addr_q   <= 8'h00;
			hreadyout_q <= 1'b1;
			hresp_q     <= 1'b0;
		end else begin
			ap_wr_q     <= ap_take && hwrite;
			ap_addr_q   <= haddr;
			hreadyout_q <= 1'b1;
			hresp_q     <= 1'b0;
		end
	end

	// Read data prepared at the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h0000_0000;
		end else if (ap_take && !hwrite) begin
			case (haddr)
				H_STAT:  hrdata_q <= {15'h0000, bus.standby_grant, last_q, 7'h00, busy_q};
				H_STBY:  hrdata_q <= {31'h0000_0000, bus.standby_req};
				default: hrdata_q <= 32'h0000_0000;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Link request launch; busy until the answer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus.req   <= 1'b0;
			bus.wr    <= 1'b0;
			bus.word  <= 1'b0;
			bus.idx   <= 2'h0;
			bus.wdata <= 16'h0000;
			busy_q    <= 1'b0;
		end else begin
			bus.req <= launch;
			if (launch) begin
				bus.wr    <= hwdata[CMD_WR];
				bus.word  <= hwdata[CMD_WORD]; // R21
				bus.idx   <= hwdata[CMD_IDX +: 2];
				bus.wdata <= hwdata[15:0];
				busy_q    <= 1'b1;
			end else if (bus.ack) begin
				busy_q <= 1'b0;
			end
		end
	end

	// Last read byte and standby wish
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			last_q          <= 8'h00;
			bus.standby_req <= 1'b0;
		end else begin
			if (bus.ack && !bus.wr) begin
				last_q <= bus.rdata;
			end
			if (ap_wr_q && ap_addr_q == H_STBY) begin
				bus.standby_req <= hwdata[0]; // R14
			end else if (bus.standby_grant) begin
				bus.standby_req <= 1'b0; // Consumed once granted, so wake does not re-enter
			end
		end
	end

endmodule

// ---- dv/wdt_props.sv ----
// Checker for the watchdog link and the device pins.
// Assumes one clock; the bench instantiates it beside the link.
`timescale 1ns/1ps
module wdt_props (
	input wire logic       hclk,            // Clock
	input wire logic       hresetn,         // Reset, low
	input wire logic       req,             // Link request
	input wire logic       ack,             // Link answer
	input wire logic       standby_req,     // Standby wish
	input wire logic       standby_grant,   // Standby granted
	input wire logic       ext_ovf_out_n_q, // Overflow output, low
	input wire logic       chip_reset_q,    // Chip reset
	input wire logic       reset_kind_q,    // Reset kind
	input wire logic       interval_irq_q   // Interval interrupt
);
	logic [8:0] lo_q; // Cycles output low
	logic [9:0] hi_q; // Cycles reset high

	////////////////////////////////////////////////////////////////
	// Pulse length counters
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			lo_q <= 9'h000;
		else
			lo_q <= ext_ovf_out_n_q ? 9'h000 : lo_q + 9'h001;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hi_q <= 10'h000;
		else
			hi_q <= chip_reset_q ? hi_q + 10'h001 : 10'h000;
	end

	////////////////////////////////////////////////////////////////
	// Properties
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	link_ack_a: assert property (req |=> ack && !req)
		else $error("link answer missing");
	ack_cause_a: assert property (ack |-> $past(req))
		else $error("answer without request");
	ovf_len_a: assert property ($rose(ext_ovf_out_n_q) |-> lo_q == 9'h080)
		else $error("overflow output length wrong");
	ovf_max_a: assert property (lo_q <= 9'h080)
		else $error("overflow output too long");
	crst_len_a: assert property ($fell(chip_reset_q) |-> hi_q == 10'h200)
		else $error("chip reset length wrong");
	crst_start_a: assert property ($rose(chip_reset_q) |-> $fell(ext_ovf_out_n_q))
		else $error("chip reset not with overflow output");
	kind_hold_a: assert property (chip_reset_q && $past(chip_reset_q) |->
		$stable(reset_kind_q))
		else $error("reset kind moved");
	irq_mode_a: assert property ($fell(ext_ovf_out_n_q) |-> !$rose(interval_irq_q))
		else $error("interrupt in watchdog mode");
	grant_cause_a: assert property ($rose(standby_grant) |-> $past(standby_req))
		else $error("standby without request");
endmodule

// ---- dv/watchdog_reset_interval_timer_tb.sv ----
// Bench for host and device joined by the link; AHB-Lite drives the host.
// Assumes zero-wait host and the register layout of the package.
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin n_errors++; \
	$display("mismatch %s exp %h got %h", n, e, s); end end
`define WT(c, l) begin t = 0; while (!(c) && t < l) begin @(negedge hclk); t++; end \
	if (!(c)) begin n_errors++; $display("mismatch wait exp 1 got 0"); end end
module watchdog_reset_interval_timer_tb;
	import wdt_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, pin_n, wake, hresp;
	logic        hready, ovf_n, crst, kind, irq, cstop, pinit, en, k;
	logic [7:0]  haddr, b;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] hwdata, hrdata, r, seed, v;
	int          n_errors, n_tests, t, c;

	wdt_if w_if();
	wdt_host i_wdt_host(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
		.hwdata(hwdata), .hrdata_q(hrdata), .hreadyout_q(hready), .hresp_q(hresp),
		.bus(w_if));
	wdt_device i_wdt_device(.hclk(hclk), .hresetn(hresetn), .bus(w_if),
		.ext_reset_pin_n(pin_n), .wake_pin(wake), .ext_ovf_out_n_q(ovf_n),
		.chip_reset_q(crst), .reset_kind_q(kind), .interval_irq_q(irq),
		.clock_stop_q(cstop), .port_init_q(pinit));
	wdt_props i_wdt_props(.hclk(hclk), .hresetn(hresetn), .req(w_if.req),
		.ack(w_if.ack), .standby_req(w_if.standby_req),
		.standby_grant(w_if.standby_grant), .ext_ovf_out_n_q(ovf_n),
		.chip_reset_q(crst), .reset_kind_q(kind), .interval_irq_q(irq));

	////////////////////////////////////////////////////////////////
	// Clock and expectations
	always #12.5 hclk = ~hclk;

	function automatic logic [7:0] stat_e(input logic f, e, s);
		stat_e = {f, e, s, 5'h1F};
	endfunction
	// Cycles to first overflow: from zero for code 0, from FF otherwise
	function automatic int span(input int c);
		span = (c == 0) ? 512 : (c < 6) ? (32 << c) : (1024 << (c - 4));
	endfunction

	////////////////////////////////////////////////////////////////
	// Bus tasks
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask
	task automatic lnk(input logic w, o, input logic [1:0] ix, input logic [15:0] d);
		logic [31:0] q;
		ahb(1'b1, H_CMD, {12'h000, ix, o, w, d}, q);
		q = 32'h1;
		for (int i = 0; i < 8 && q[0] !== 1'b0; i++)
			ahb(1'b0, H_STAT, 32'h0, q);
		if (q[0] !== 1'b0) begin
			n_errors++;
			$display("mismatch link_busy exp 0 got 1");
		end
		b = q[15:8];
	endtask
	task automatic wr(input logic [1:0] ix, input logic [7:0] key, dat);
		lnk(1'b1, 1'b1, ix, {key, dat});
	endtask
	task automatic rd(input logic [1:0] ix);
		lnk(1'b0, 1'b0, ix, 16'h0000);
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// Scenarios
	initial begin
		seed = 32'hc2255a9c;
		{hclk, hresetn, hsel, hwrite, wake, haddr, htrans, hwdata} = '0;
		hsize = 3'h2;
		pin_n = 1'b1;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (4) @(posedge hclk);
		// Reset values and unmapped offset
		rd(IDX_CTRL);
		`CHK("ctrl", 8'h18, b)
		rd(IDX_RSTRD);
		`CHK("stat", stat_e(0, 0, 0), b)
		ahb(1'b0, 8'h0C, 32'h0, r);
		`CHK("unmapped", 32'h0, r)
		`CHK("hresp", 1'b0, hresp)
		// Keyed counter writes: byte and wrong key refused
		v = $random(seed);
		wr(IDX_CTRL, KEY_A5, 8'h27);
		lnk(1'b1, 1'b0, IDX_CTRL, {KEY_5A, v[7:0]});
		rd(IDX_CNT);
		`CHK("cnt_byte", 8'h00, b)
		wr(IDX_CTRL, 8'h33, v[7:0]);
		rd(IDX_CNT);
		`CHK("cnt_key", 8'h00, b)
		wr(IDX_CTRL, KEY_5A, v[7:0]);
		rd(IDX_CNT);
		`CHK("cnt_word", v[7:0], b)
		wr(IDX_CTRL, KEY_A5, 8'h00);
		rd(IDX_CNT);
		`CHK("cnt_stop", 8'h00, b)
		// Interval mode at every divider code
		for (c = 0; c < 8; c++) begin
			wr(IDX_CTRL, KEY_A5, {5'h04, c[2:0]});
			if (c > 0)
				wr(IDX_CTRL, KEY_5A, CNT_TOP);
			`WT(irq === 1'b1, 20000)
			`CHK("irq", 1'b1, irq)
			`CHK("span", 1'b1, t + 48 >= span(c) && t <= span(c) + 8)
			rd(IDX_CTRL);
			`CHK("ovf", {5'h17, c[2:0]}, b)
			rd(IDX_RSTRD);
			`CHK("watchdog_overflow_flag_int", stat_e(0, 0, 0), b)
			wr(IDX_CTRL, KEY_A5, {5'h04, c[2:0]});
			`CHK("irq_clr", 1'b0, irq)
			wr(IDX_CTRL, KEY_A5, 8'h00);
		end
		// Watchdog overflow with chip reset on, then off
		v = $random(seed);
		k = v[0];
		for (c = 0; c < 2; c++) begin
			en = (c == 0);
			wr(IDX_RSTW, KEY_5A, {1'b0, en, k, 5'h1F});
			wr(IDX_CTRL, KEY_A5, 8'h60);
			`WT(ovf_n === 1'b0, 2000)
			`CHK("ovf_out", 1'b0, ovf_n)
			`CHK("crst", en, crst)
			if (en)
				`CHK("kind", k, kind)
			`CHK("pinit_wd", 1'b0, pinit)
			rd(IDX_CTRL);
			`CHK("ctrl_clr", 8'h18, b)
			wr(IDX_RSTW, KEY_A5, ZERO_B);
			rd(IDX_RSTRD);
			`CHK("watchdog_overflow_flag_set", stat_e(1, en, k), b)
			wr(IDX_RSTW, KEY_A5, ZERO_B);
			rd(IDX_RSTRD);
			`CHK("watchdog_overflow_flag_clr", stat_e(0, en, k), b)
			`WT(crst === 1'b0 && ovf_n === 1'b1, 700)
		end
		// Kicks hold off overflow; then pin reset clears the flag, inits ports
		wr(IDX_CTRL, KEY_A5, 8'h60);
		repeat (3) begin
			repeat (300) @(posedge hclk);
			wr(IDX_CTRL, KEY_5A, ZERO_B);
		end
		`CHK("kick", 1'b1, ovf_n)
		`WT(ovf_n === 1'b0, 2000)
		`WT(ovf_n === 1'b1, 300)
		@(posedge hclk);
		pin_n <= 1'b0;
		repeat (4) @(posedge hclk);
		`CHK("pinit", 1'b1, pinit)
		pin_n <= 1'b1;
		repeat (4) @(posedge hclk);
		rd(IDX_RSTRD);
		`CHK("watchdog_overflow_flag_pin", stat_e(0, 0, 0), b)
		// Standby refused while running, then woken
		wr(IDX_CTRL, KEY_A5, 8'h20);
		ahb(1'b1, H_STBY, 32'h1, r);
		ahb(1'b0, H_STAT, 32'h0, r);
		`CHK("grant_run", 1'b0, r[16])
		wr(IDX_CTRL, KEY_A5, 8'h00);
		ahb(1'b0, H_STAT, 32'h0, r);
		`CHK("grant", 1'b1, r[16])
		`CHK("cstop", 1'b1, cstop)
		@(posedge hclk);
		wake <= 1'b1;
		`WT(cstop === 1'b0, 1000)
		`CHK("wake", 1'b1, t > 480 && t < 560)
		repeat (4) @(posedge hclk);
		`CHK("stay_awake", 1'b0, cstop)
		ahb(1'b1, H_STBY, 32'h0, r);
		wake <= 1'b0;
		tally_and_finish;
	end

	// Hang guard
	initial begin
		repeat (60000) @(posedge hclk);
		n_errors++;
		tally_and_finish;
	end
endmodule
